// *** include/nfa_pkg.sv ***
// package: register map, field positions and reset values of the nvm access block
package nfa_pkg;
    // register byte addresses (word aligned)
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_UNLOCK    = 8'h04;
    localparam logic [7:0] ADDR_ADDR_LOW  = 8'h08;
    localparam logic [7:0] ADDR_ADDR_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_DATA_LOW  = 8'h10;
    localparam logic [7:0] ADDR_DATA_HIGH = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1C;
    // control register field positions
    localparam int BIT_MEM_SPACE   = 7;
    localparam int BIT_CFG_SPACE   = 6;
    localparam int BIT_LATCH_ONLY  = 5;
    localparam int BIT_ERASE       = 4;
    localparam int BIT_WR_ERROR    = 3;
    localparam int BIT_WR_ENABLE   = 2;
    localparam int BIT_WR_START    = 1;
    localparam int BIT_RD_START    = 0;
    // interrupt status/mask field positions
    localparam int IRQ_WR_DONE     = 0;
    localparam int IRQ_RD_DONE     = 1;
    // unlock pattern
    localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    // reset values
    localparam logic [7:0] RST_CONTROL   = 8'h00;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [6:0] RST_ADDR_HIGH = 7'h00;
    localparam logic [5:0] RST_DATA_HIGH = 6'h00;
    localparam logic [1:0] RST_IRQ       = 2'h0;
    // unimplemented bit fill patterns
    localparam logic       ADDR_HIGH_FILL = 1'b1;
    // write operation length in cycles (stands in for the self-timed write)
    localparam logic [3:0] WRITE_CYCLES  = 4'h4;
    typedef enum logic [1:0] {
        NFA_UNL_IDLE,
        NFA_UNL_GOT55,
        NFA_UNL_ARMED
    } nfa_unlock_t;
endpackage

// *** hw/nfa_core.sv ***
// nvm access control: wishbone registers, unlock sequencer, read/write start
`timescale 1ns/100ps
// Overview of operation
// - read start only settable by software writes
// - unlock register is write only, no storage
// - control bits: space, cfg, latches, erase, flags
// - address high seven bits, bit7 reads one
// - data high six bits, upper bits zero
// - write start reads zero when idle
module nfa_core (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic             mem_rd_o,
    output logic             mem_wr_o,
    output logic      [14:0] mem_addr_o,
    input  wire logic [13:0] mem_rdata_i,
    output logic             irq_o
);
    // --------------------------------------------------------------
    // bus decode
    // --------------------------------------------------------------
    logic        req;
    logic        wr_req;
    logic        mapped;
    logic [7:0]  wbyte;
    logic        ack_q;
    logic        err_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    assign req    = wb_cyc_i && wb_stb_i && !ack_q && !err_q && ce_i;
    assign mapped = hit(wb_adr_i, nfa_pkg::ADDR_CONTROL)
                 || hit(wb_adr_i, nfa_pkg::ADDR_UNLOCK)
                 || hit(wb_adr_i, nfa_pkg::ADDR_ADDR_LOW)
                 || hit(wb_adr_i, nfa_pkg::ADDR_ADDR_HIGH)
                 || hit(wb_adr_i, nfa_pkg::ADDR_DATA_LOW)
                 || hit(wb_adr_i, nfa_pkg::ADDR_DATA_HIGH)
                 || hit(wb_adr_i, nfa_pkg::ADDR_IRQ_STAT)
                 || hit(wb_adr_i, nfa_pkg::ADDR_IRQ_MASK);
    // only lane 0 carries the byte registers
    assign wr_req = req && wb_we_i && mapped && wb_sel_i[0];
    assign wbyte  = wb_dat_i[7:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= req && mapped;
            err_q <= req && !mapped;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;

    // --------------------------------------------------------------
    // unlock sequencer
    // --------------------------------------------------------------
    nfa_pkg::nfa_unlock_t unl_q;
    logic                 wr_start_req;
    logic                 wr_go;
    logic [7:0]           ctl_q;
    logic                 busy_q;

    assign wr_start_req = wr_req && hit(wb_adr_i, nfa_pkg::ADDR_CONTROL)
                       && wbyte[nfa_pkg::BIT_WR_START];
    // write accepted only right after the full pattern, with enable set
    assign wr_go = wr_start_req && (unl_q == nfa_pkg::NFA_UNL_ARMED)
                && ctl_q[nfa_pkg::BIT_WR_ENABLE]
                && wbyte[nfa_pkg::BIT_WR_ENABLE] && !busy_q;

    // pattern bytes are only compared, never stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unl_q <= nfa_pkg::NFA_UNL_IDLE;
        end else if (ce_i && wr_req) begin
            if (hit(wb_adr_i, nfa_pkg::ADDR_UNLOCK)) begin
                unique case (unl_q)
                    nfa_pkg::NFA_UNL_IDLE:
                        unl_q <= (wbyte == nfa_pkg::UNLOCK_FIRST)
                               ? nfa_pkg::NFA_UNL_GOT55
                               : nfa_pkg::NFA_UNL_IDLE;
                    nfa_pkg::NFA_UNL_GOT55:
                        unl_q <= (wbyte == nfa_pkg::UNLOCK_SECOND)
                               ? nfa_pkg::NFA_UNL_ARMED
                               : nfa_pkg::NFA_UNL_IDLE;
                    nfa_pkg::NFA_UNL_ARMED:
                        unl_q <= (wbyte == nfa_pkg::UNLOCK_FIRST)
                               ? nfa_pkg::NFA_UNL_GOT55
                               : nfa_pkg::NFA_UNL_IDLE;
                endcase
            end else begin
                // any write to another mapped register breaks the sequence
                unl_q <= nfa_pkg::NFA_UNL_IDLE;
            end
        end
    end

    // --------------------------------------------------------------
    // control register and write timer
    // --------------------------------------------------------------
    logic [3:0] wcnt_q;
    logic       wr_done;
    logic       rd_go;

    assign rd_go   = wr_req && hit(wb_adr_i, nfa_pkg::ADDR_CONTROL)
                  && wbyte[nfa_pkg::BIT_RD_START] && !busy_q;
    assign wr_done = busy_q && (wcnt_q == 4'h1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            wcnt_q <= 4'h0;
        end else if (ce_i) begin
            if (wr_go) begin
                busy_q <= 1'b1;
                wcnt_q <= nfa_pkg::WRITE_CYCLES;
            end else if (wr_done) begin
                busy_q <= 1'b0;
                wcnt_q <= 4'h0;
            end else if (busy_q) begin
                wcnt_q <= wcnt_q - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= nfa_pkg::RST_CONTROL;
        end else if (ce_i) begin
            if (wr_req && hit(wb_adr_i, nfa_pkg::ADDR_CONTROL) && !busy_q) begin
                // plain bits 7..4 and 2 follow software
                ctl_q[7:4] <= wbyte[7:4];
                ctl_q[nfa_pkg::BIT_WR_ENABLE] <= wbyte[nfa_pkg::BIT_WR_ENABLE];
                // error flag: software may only clear it
                if (!wbyte[nfa_pkg::BIT_WR_ERROR])
                    ctl_q[nfa_pkg::BIT_WR_ERROR] <= 1'b0;
            end
            // write start set only on a legal attempt
            ctl_q[nfa_pkg::BIT_WR_START] <= wr_go ||
                (busy_q && !wr_done);
            // read start is a one-cycle pulse, zero write ignored
            ctl_q[nfa_pkg::BIT_RD_START] <= rd_go;
        end
    end

    // --------------------------------------------------------------
    // address and data registers
    // --------------------------------------------------------------
    logic [7:0] adl_q;
    logic [6:0] adh_q;
    logic [7:0] dtl_q;
    logic [5:0] dth_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adl_q <= nfa_pkg::RST_BYTE;
            adh_q <= nfa_pkg::RST_ADDR_HIGH;
        end else if (ce_i && wr_req && !busy_q) begin
            if (hit(wb_adr_i, nfa_pkg::ADDR_ADDR_LOW))
                adl_q <= wbyte;
            if (hit(wb_adr_i, nfa_pkg::ADDR_ADDR_HIGH))
                adh_q <= wbyte[6:0];
        end
    end

    // read data lands one cycle after the start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dtl_q <= nfa_pkg::RST_BYTE;
            dth_q <= nfa_pkg::RST_DATA_HIGH;
        end else if (ce_i) begin
            if (ctl_q[nfa_pkg::BIT_RD_START]) begin
                dtl_q <= mem_rdata_i[7:0];
                dth_q <= mem_rdata_i[13:8];
            end else if (wr_req && !busy_q) begin
                if (hit(wb_adr_i, nfa_pkg::ADDR_DATA_LOW))
                    dtl_q <= wbyte;
                if (hit(wb_adr_i, nfa_pkg::ADDR_DATA_HIGH))
                    dth_q <= wbyte[5:0];
            end
        end
    end

    assign mem_addr_o = {adh_q, adl_q};
    assign mem_rd_o   = ctl_q[nfa_pkg::BIT_RD_START];
    assign mem_wr_o   = wr_go;

    // --------------------------------------------------------------
    // interrupt status and mask
    // --------------------------------------------------------------
    logic [1:0] ist_q;
    logic [1:0] imk_q;
    logic [1:0] ev;

    assign ev = {ctl_q[nfa_pkg::BIT_RD_START], wr_done};

    // set wins over a same-cycle write-one-to-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_q <= nfa_pkg::RST_IRQ;
            imk_q <= nfa_pkg::RST_IRQ;
        end else if (ce_i) begin
            if (wr_req && hit(wb_adr_i, nfa_pkg::ADDR_IRQ_STAT))
                ist_q <= (ist_q & ~wbyte[1:0]) | ev;
            else
                ist_q <= ist_q | ev;
            if (wr_req && hit(wb_adr_i, nfa_pkg::ADDR_IRQ_MASK))
                imk_q <= wbyte[1:0];
        end
    end
    assign irq_o = |(ist_q & imk_q);

    // --------------------------------------------------------------
    // read mux
    // --------------------------------------------------------------
    logic [7:0] rbyte;
    always_comb begin
        rbyte = 8'h00;
        unique case (1'b1)
            hit(wb_adr_i, nfa_pkg::ADDR_CONTROL):   rbyte = ctl_q;
            hit(wb_adr_i, nfa_pkg::ADDR_ADDR_LOW):  rbyte = adl_q;
            hit(wb_adr_i, nfa_pkg::ADDR_ADDR_HIGH):
                rbyte = {nfa_pkg::ADDR_HIGH_FILL, adh_q};
            hit(wb_adr_i, nfa_pkg::ADDR_DATA_LOW):  rbyte = dtl_q;
            hit(wb_adr_i, nfa_pkg::ADDR_DATA_HIGH):
                rbyte = {2'h0, dth_q};
            hit(wb_adr_i, nfa_pkg::ADDR_IRQ_STAT):  rbyte = {6'h00, ist_q};
            hit(wb_adr_i, nfa_pkg::ADDR_IRQ_MASK):  rbyte = {6'h00, imk_q};
            default:                                rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (ce_i && req)
            wb_dat_o <= {24'h00_0000, rbyte};
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_rd_pulse;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && ctl_q[0] ##1 ce_i |-> !ctl_q[0];
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("rd stuck");

    property p_rd_set;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && rd_go |=> ctl_q[0] && mem_rd_o;
    endproperty
    a_rd_set: assert property (p_rd_set) else $error("rd not set");

    // judged from the start bit itself, not from the accept term
    property p_wr_lock;
        @(posedge clk_i) disable iff (rst_i)
        $rose(ctl_q[nfa_pkg::BIT_WR_START])
        |-> $past(unl_q == nfa_pkg::NFA_UNL_ARMED) && $past(ctl_q[2]);
    endproperty
    a_wr_lock: assert property (p_wr_lock) else $error("unlocked");

    sequence s_wr_run;
        ce_i && wr_go ##1 ce_i[*4];
    endsequence

    // busy drops at the fourth running edge, seen one edge later
    property p_wr_len;
        @(posedge clk_i) disable iff (rst_i)
        s_wr_run |=> !busy_q && !ctl_q[1];
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("wr length");

    property p_adh_fill;
        @(posedge clk_i) disable iff (rst_i)
        hit(wb_adr_i, nfa_pkg::ADDR_ADDR_HIGH) |-> rbyte[7];
    endproperty
    a_adh_fill: assert property (p_adh_fill) else $error("adh bit7");

    property p_dth_zero;
        @(posedge clk_i) disable iff (rst_i)
        hit(wb_adr_i, nfa_pkg::ADDR_DATA_HIGH) |-> rbyte[7:6] == 2'h0;
    endproperty
    a_dth_zero: assert property (p_dth_zero) else $error("dth high");

    property p_unl_read;
        @(posedge clk_i) disable iff (rst_i)
        hit(wb_adr_i, nfa_pkg::ADDR_UNLOCK) |-> rbyte == 8'h00;
    endproperty
    a_unl_read: assert property (p_unl_read) else $error("unl read");

    property p_ctl_wr;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wr_req && hit(wb_adr_i, nfa_pkg::ADDR_CONTROL) && !busy_q
        |=> ctl_q[7:4] == $past(wbyte[7:4]);
    endproperty
    a_ctl_wr: assert property (p_ctl_wr) else $error("ctl bits");
endmodule // nfa_core

// *** testbench/nfa_core_tb.sv ***
// self-checking bench for the nvm access control block
`timescale 1ns/100ps
module nfa_core_tb;
    // ----------------------------------------------------------------
    // signals and design
    // ----------------------------------------------------------------
    logic        clk_i;
    logic        rst_i;
    logic        ce_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        wb_err_o;
    logic        mem_rd_o;
    logic        mem_wr_o;
    logic [14:0] mem_addr_o;
    logic [13:0] mem_rdata_i;
    logic        irq_o;
    logic [31:0] rd;
    logic        er;
    int          errors;
    int          cmp_count;
    int          rd_pulses;
    int          wr_pulses;

    nfa_core nfa_core_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
        .mem_rdata_i(mem_rdata_i), .irq_o(irq_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // strobes counted at the edge, so a pulse is never missed
    always @(posedge clk_i) begin
        if (mem_rd_o === 1'b1) rd_pulses++;
        if (mem_wr_o === 1'b1) wr_pulses++;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // classic cycle: held until ack or err is seen at a rising edge
    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [7:0] dat);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h000000, dat};
        n = 0;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20) errors++;
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        bus(1'b1, adr, dat);
    endtask

    task automatic rchk(input string nm, input logic [7:0] adr,
                        input logic [7:0] exp);
        bus(1'b0, adr, 8'h00);
        check(nm, rd, {24'h000000, exp});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rchk("ctrl rst", nfa_pkg::ADDR_CONTROL, 8'h00);
        rchk("ahi rst", nfa_pkg::ADDR_ADDR_HIGH, 8'h80);
        rchk("dhi rst", nfa_pkg::ADDR_DATA_HIGH, 8'h00);
        wr(nfa_pkg::ADDR_ADDR_HIGH, 8'h7F);
        rchk("ahi", nfa_pkg::ADDR_ADDR_HIGH, 8'hFF);
        wr(nfa_pkg::ADDR_DATA_HIGH, 8'hFF);
        rchk("dhi", nfa_pkg::ADDR_DATA_HIGH, 8'h3F);
        wr(nfa_pkg::ADDR_UNLOCK, 8'h5A);
        rchk("unlock", nfa_pkg::ADDR_UNLOCK, 8'h00);
        bus(1'b0, 8'h20, 8'h00);
        check("unmapped err", {31'h0, er}, 32'h1);
        // error flag may only be cleared by software
        wr(nfa_pkg::ADDR_CONTROL, 8'hFC);
        rchk("ctrl fields", nfa_pkg::ADDR_CONTROL, 8'hF4);
        wr(nfa_pkg::ADDR_CONTROL, 8'h00);
    endtask

    task automatic t_read();
        wr(nfa_pkg::ADDR_ADDR_LOW, 8'h34);
        wr(nfa_pkg::ADDR_ADDR_HIGH, 8'h12);
        check("mem addr", {17'h0, mem_addr_o}, 32'h1234);
        wr(nfa_pkg::ADDR_CONTROL, 8'h01);
        repeat (3) @(posedge clk_i);
        check("rd pulses", rd_pulses, 32'h1);
        rchk("rd clr", nfa_pkg::ADDR_CONTROL, 8'h00);
        rchk("dlo", nfa_pkg::ADDR_DATA_LOW, 8'h5C);
        rchk("dhi", nfa_pkg::ADDR_DATA_HIGH, 8'h2A);
        rchk("stat rd", nfa_pkg::ADDR_IRQ_STAT, 8'h02);
        check("irq masked", {31'h0, irq_o}, 32'h0);
        wr(nfa_pkg::ADDR_IRQ_MASK, 8'h02);
        check("irq on", {31'h0, irq_o}, 32'h1);
        wr(nfa_pkg::ADDR_IRQ_STAT, 8'h02);
        check("irq clr", {31'h0, irq_o}, 32'h0);
    endtask

    task automatic unlock_go(input logic [7:0] ctl, input logic [7:0] exp);
        wr(nfa_pkg::ADDR_UNLOCK, 8'h55);
        wr(nfa_pkg::ADDR_UNLOCK, 8'hAA);
        wr(nfa_pkg::ADDR_CONTROL, ctl);
        // read back while the write is still running
        rchk("wr busy", nfa_pkg::ADDR_CONTROL, exp);
        repeat (10) @(posedge clk_i);
    endtask

    // a request held while the clock enable is low must wait
    task automatic t_hold();
        @(posedge clk_i);
        ce_i     <= 1'b0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= 1'b1;
        wb_adr_i <= nfa_pkg::ADDR_ADDR_LOW;
        wb_dat_i <= 32'h0000_00A5;
        repeat (3) @(posedge clk_i);
        check("hold ack", {31'h0, wb_ack_o}, 32'h0);
        ce_i <= 1'b1;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        rchk("hold adl", nfa_pkg::ADDR_ADDR_LOW, 8'hA5);
    endtask

    task automatic t_write();
        wr(nfa_pkg::ADDR_CONTROL, 8'h04);
        wr(nfa_pkg::ADDR_CONTROL, 8'h06);
        rchk("no unlock", nfa_pkg::ADDR_CONTROL, 8'h04);
        // an intervening write must break the pattern
        wr(nfa_pkg::ADDR_UNLOCK, 8'h55);
        wr(nfa_pkg::ADDR_ADDR_LOW, 8'h00);
        wr(nfa_pkg::ADDR_UNLOCK, 8'hAA);
        wr(nfa_pkg::ADDR_CONTROL, 8'h06);
        check("broken", wr_pulses, 32'h0);
        unlock_go(8'h06, 8'h06);
        check("wr pulses", wr_pulses, 32'h1);
        bus(1'b0, nfa_pkg::ADDR_CONTROL, 8'h00);
        check("wr idle", {31'h0, rd[1]}, 32'h0);
        rchk("stat wr", nfa_pkg::ADDR_IRQ_STAT, 8'h01);
        check("irq masked", {31'h0, irq_o}, 32'h0);
        wr(nfa_pkg::ADDR_IRQ_MASK, 8'h03);
        check("irq on", {31'h0, irq_o}, 32'h1);
        wr(nfa_pkg::ADDR_IRQ_STAT, 8'h01);
        check("irq clr", {31'h0, irq_o}, 32'h0);
        wr(nfa_pkg::ADDR_CONTROL, 8'h00);
        unlock_go(8'h02, 8'h00);
        check("no enable", wr_pulses, 32'h1);
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        mem_rdata_i = 14'h2A5C;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_read();
        t_write();
        t_hold();
        give_verdict();
    end

    // whole run needs under two hundred cycles; allow ample margin
    initial begin
        #(3000 * 100);
        errors++;
        give_verdict();
    end
endmodule // nfa_core_tb
